/* hw/arcs_pkg.sv */
// Package: register map, field layout and channel codes of the reference/channel select block
package arcs_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [15:0] REF_SEL_OFS   = 16'h1D2B;
    localparam logic [15:0] PCH_SEL_OFS   = 16'h1D1F;
    localparam logic [7:0]  REF_SEL_RST   = 8'h00;
    localparam logic [7:0]  PCH_SEL_RST   = 8'h00;

    // ************************************************************
    // Field layout
    // ************************************************************
    localparam int          NEG_REF_BIT   = 4;
    localparam int          POS_REF_LSB   = 0;
    localparam int          POS_REF_W     = 2;
    localparam int          PCH_W         = 6;
    localparam logic [7:0]  REF_SEL_MASK  = 8'h13;
    localparam logic [7:0]  PCH_SEL_MASK  = 8'h3F;

    // ************************************************************
    // Positive reference codes
    // ************************************************************
    localparam logic [1:0]  POS_REF_SEL_SUPPLY   = 2'h0;
    localparam logic [1:0]  POS_REF_SEL_RSVD     = 2'h1;
    localparam logic [1:0]  POS_REF_SEL_EXT      = 2'h2;
    localparam logic [1:0]  POS_REF_SEL_FIXED    = 2'h3;

    // ************************************************************
    // Channel codes
    // ************************************************************
    localparam logic [5:0]  PCH_FVR_BUF2  = 6'h3F;
    localparam logic [5:0]  PCH_FVR_BUF1  = 6'h3E;
    localparam logic [5:0]  PCH_DAC2      = 6'h3D;
    localparam logic [5:0]  PCH_DAC1      = 6'h3C;
    localparam logic [5:0]  PCH_TEMP      = 6'h3B;
    localparam logic [5:0]  PCH_AGND      = 6'h3A;
    localparam logic [5:0]  PCH_RSVD_HI   = 6'h39;
    localparam logic [5:0]  PCH_RSVD_LO   = 6'h24;
    localparam int          PCH_EXT_N     = 36;

    // High reference source
    typedef enum logic [1:0] {
        ARCS_HREF_SUPPLY,
        ARCS_HREF_EXT,
        ARCS_HREF_FIXED,
        ARCS_HREF_NONE
    } arcs_href_e;

    // Positive input source kind
    typedef enum logic [2:0] {
        ARCS_SRC_EXT,
        ARCS_SRC_FVR_BUF1,
        ARCS_SRC_FVR_BUF2,
        ARCS_SRC_DAC1,
        ARCS_SRC_DAC2,
        ARCS_SRC_TEMP,
        ARCS_SRC_AGND,
        ARCS_SRC_NONE
    } arcs_src_e;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } arcs_bus_s;

    // Analog routing controls
    typedef struct packed {
        logic                  low_ref_ext;
        arcs_href_e            high_ref;
        arcs_src_e             src;
        logic [PCH_EXT_N-1:0]  ext_onehot;
    } arcs_route_s;

endpackage : arcs_pkg

/* hw/arcs_reg8.sv */
// Module: one 8-bit control register with write mask and synchronous reset
module arcs_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK    = 8'hFF
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // Write port
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    // Stored value
    output logic      [7:0] q
);

    logic [7:0] q_reg;
    logic [7:0] q_next;

    // Unimplemented bits never store
    always_comb begin
        q_next = q_reg;
        if (we) begin
            q_next = wdata & MASK;
        end
    end

    // Register stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q_reg <= RST_VAL;
        end else if (clk_en) begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : arcs_reg8

/* hw/arcs_decode.sv */
// Module: decodes stored fields into analog routing controls
module arcs_decode (
    // Stored fields
    input  wire logic [7:0]         ref_sel,
    input  wire logic [7:0]         pch_sel,
    // Routing controls
    output arcs_pkg::arcs_route_s   route
);

    logic [1:0] pos_ref_sel;
    logic [5:0] code;

    assign pos_ref_sel = ref_sel[arcs_pkg::POS_REF_LSB +: arcs_pkg::POS_REF_W];
    assign code = pch_sel[arcs_pkg::PCH_W-1:0];

    // Reference and channel decode
    always_comb begin
        route.low_ref_ext = ref_sel[arcs_pkg::NEG_REF_BIT];
        unique case (pos_ref_sel)
            arcs_pkg::POS_REF_SEL_FIXED:  route.high_ref = arcs_pkg::ARCS_HREF_FIXED;
            arcs_pkg::POS_REF_SEL_EXT:    route.high_ref = arcs_pkg::ARCS_HREF_EXT;
            arcs_pkg::POS_REF_SEL_SUPPLY: route.high_ref = arcs_pkg::ARCS_HREF_SUPPLY;
            default:               route.high_ref = arcs_pkg::ARCS_HREF_NONE;
        endcase
        route.ext_onehot = '0;
        if (code == arcs_pkg::PCH_FVR_BUF2) begin
            route.src = arcs_pkg::ARCS_SRC_FVR_BUF2;
        end else if (code == arcs_pkg::PCH_FVR_BUF1) begin
            route.src = arcs_pkg::ARCS_SRC_FVR_BUF1;
        end else if (code == arcs_pkg::PCH_DAC2) begin
            route.src = arcs_pkg::ARCS_SRC_DAC2;
        end else if (code == arcs_pkg::PCH_DAC1) begin
            route.src = arcs_pkg::ARCS_SRC_DAC1;
        end else if (code == arcs_pkg::PCH_TEMP) begin
            route.src = arcs_pkg::ARCS_SRC_TEMP;
        end else if (code == arcs_pkg::PCH_AGND) begin
            route.src = arcs_pkg::ARCS_SRC_AGND;
        end else if (code >= arcs_pkg::PCH_RSVD_LO) begin
            route.src = arcs_pkg::ARCS_SRC_NONE;
        end else begin
            route.src = arcs_pkg::ARCS_SRC_EXT;
            route.ext_onehot[code] = 1'b1;
        end
    end

endmodule : arcs_decode

/* hw/arcs_top.sv */
// Module: reference and positive-channel select registers of the converter
//
// Contract
// - Bit 4 of the reference register routes the low reference to the external pin when 1, ground when 0.
// - Positive-reference code 11 connects the high reference to the fixed voltage reference.
// - Positive-reference code 10 picks the external pin, 00 the supply, and 01 is reserved.
// - The channel register holds a six-bit read/write code in bits 5:0, zero after reset, steering the input mux.
// - Channel code 111111 connects the input to the second fixed-reference buffer.
// - Channel code 111110 connects the input to the first fixed-reference buffer.
// - Codes 111101/111100 pick DAC two/one, 111011 the temperature indicator, 111010 analog ground.
// - Codes 111001 down to 100100 connect the input to nothing.
//
// Decided for this implementation: strobed register access.
module arcs_top (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // Register port
    input  wire logic [15:0]          reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Analog routing
    output arcs_pkg::arcs_route_s     route
);

    // ************************************************************
    // Address decode and storage
    // ************************************************************
    arcs_pkg::arcs_bus_s bus;
    logic [7:0]          ref_q;
    logic [7:0]          pch_q;
    logic                ref_we;
    logic                pch_we;
    logic [7:0]          rdata_reg;
    logic [7:0]          rdata_next;

    assign bus    = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign ref_we = bus.wr && (bus.addr == arcs_pkg::REF_SEL_OFS);
    assign pch_we = bus.wr && (bus.addr == arcs_pkg::PCH_SEL_OFS);

    // Reference register; mask drops reserved bits
    arcs_reg8 #(
        .RST_VAL (arcs_pkg::REF_SEL_RST),
        .MASK    (arcs_pkg::REF_SEL_MASK)
    ) u_ref (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .we      (ref_we),
        .wdata   (bus.wdata),
        .q       (ref_q)
    );

    // Channel register, six live bits
    arcs_reg8 #(
        .RST_VAL (arcs_pkg::PCH_SEL_RST),
        .MASK    (arcs_pkg::PCH_SEL_MASK)
    ) u_pch (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .we      (pch_we),
        .wdata   (bus.wdata),
        .q       (pch_q)
    );

    // ************************************************************
    // Read path
    // ************************************************************

    // Unmapped reads return zero; data held only for one cycle
    always_comb begin
        rdata_next = 8'h00;
        if (bus.rd && (bus.addr == arcs_pkg::REF_SEL_OFS)) begin
            rdata_next = ref_q & arcs_pkg::REF_SEL_MASK;
        end else if (bus.rd && (bus.addr == arcs_pkg::PCH_SEL_OFS)) begin
            rdata_next = pch_q & arcs_pkg::PCH_SEL_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // ************************************************************
    // Routing decode
    // ************************************************************
    arcs_decode u_dec (
        .ref_sel (ref_q),
        .pch_sel (pch_q),
        .route   (route)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    low_ref_route_a: assert property (route.low_ref_ext == ref_q[4])
        else $error("low reference route mismatch");
    fixed_href_a: assert property ((ref_q[1:0] == 2'h3) |-> route.high_ref == arcs_pkg::ARCS_HREF_FIXED)
        else $error("fixed reference not selected");
    ext_supply_href_a: assert property (
        ((ref_q[1:0] == 2'h2) |-> route.high_ref == arcs_pkg::ARCS_HREF_EXT) and
        ((ref_q[1:0] == 2'h0) |-> route.high_ref == arcs_pkg::ARCS_HREF_SUPPLY))
        else $error("high reference route mismatch");
    pch_write_read_a: assert property (
        (clk_en && reg_wr && reg_addr == 16'h1D1F) ##1 (clk_en && reg_rd && reg_addr == 16'h1D1F)
        |=> reg_rdata == {2'h0, $past(reg_wdata, 2) & 8'h3F})
        else $error("channel register readback wrong");
    fvr2_route_a: assert property ((pch_q[5:0] == 6'h3F) |-> route.src == arcs_pkg::ARCS_SRC_FVR_BUF2)
        else $error("buffer two not routed");
    fvr1_route_a: assert property ((pch_q[5:0] == 6'h3E) |-> route.src == arcs_pkg::ARCS_SRC_FVR_BUF1)
        else $error("buffer one not routed");
    internal_src_a: assert property (
        ((pch_q[5:0] == 6'h3D) |-> route.src == arcs_pkg::ARCS_SRC_DAC2) and
        ((pch_q[5:0] == 6'h3C) |-> route.src == arcs_pkg::ARCS_SRC_DAC1) and
        ((pch_q[5:0] == 6'h3B) |-> route.src == arcs_pkg::ARCS_SRC_TEMP) and
        ((pch_q[5:0] == 6'h3A) |-> route.src == arcs_pkg::ARCS_SRC_AGND))
        else $error("internal source route mismatch");
    reserved_open_a: assert property (
        (pch_q[5:0] >= 6'h24 && pch_q[5:0] <= 6'h39)
        |-> (route.src == arcs_pkg::ARCS_SRC_NONE && route.ext_onehot == '0))
        else $error("reserved code connects a source");
    ref_read_mask_a: assert property (
        (clk_en && reg_rd && reg_addr == 16'h1D2B) |=> (reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0))
        else $error("reserved reference bits read nonzero");

    write_ref_c: cover property (clk_en && reg_wr && reg_addr == 16'h1D2B);
    fixed_ref_c: cover property (route.high_ref == arcs_pkg::ARCS_HREF_FIXED);
    reserved_ch_c: cover property (route.src == arcs_pkg::ARCS_SRC_NONE);
    temp_ch_c: cover property (route.src == arcs_pkg::ARCS_SRC_TEMP);

endmodule : arcs_top

/* test/tb_arcs_top.sv */
// Testbench: self-checking bench for the reference and channel select registers
module tb_arcs_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Stimulus and observation
    // ************************************************************
    logic                  clk_sys;
    logic                  rst_n;
    logic                  clk_en;
    logic [15:0]           reg_addr;
    logic [7:0]            reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [7:0]            reg_rdata;
    arcs_pkg::arcs_route_s route;
    logic [7:0]            ref_m;
    logic [7:0]            pch_m;
    logic [7:0]            rd_v;
    logic [31:0]           rnd;
    integer                seed;
    integer                fails;
    integer                n_tests;

    arcs_top arcs_top_i (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .route     (route)
    );

    // Free-running 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    // ************************************************************
    // Expectation and checking
    // ************************************************************
    // Routing worked out from the two stored values
    function automatic arcs_pkg::arcs_route_s exp_route(input logic [7:0] r, input logic [7:0] p);
        arcs_pkg::arcs_route_s e;
        e = '0;
        e.low_ref_ext = r[4];
        case (r[1:0])
            2'h0: e.high_ref = arcs_pkg::ARCS_HREF_SUPPLY;
            2'h1: e.high_ref = arcs_pkg::ARCS_HREF_NONE;
            2'h2: e.high_ref = arcs_pkg::ARCS_HREF_EXT;
            default: e.high_ref = arcs_pkg::ARCS_HREF_FIXED;
        endcase
        case (p[5:0])
            6'h3F: e.src = arcs_pkg::ARCS_SRC_FVR_BUF2;
            6'h3E: e.src = arcs_pkg::ARCS_SRC_FVR_BUF1;
            6'h3D: e.src = arcs_pkg::ARCS_SRC_DAC2;
            6'h3C: e.src = arcs_pkg::ARCS_SRC_DAC1;
            6'h3B: e.src = arcs_pkg::ARCS_SRC_TEMP;
            6'h3A: e.src = arcs_pkg::ARCS_SRC_AGND;
            default: e.src = arcs_pkg::ARCS_SRC_NONE;
        endcase
        if (p[5:0] < 6'h24) begin
            e.src = arcs_pkg::ARCS_SRC_EXT;
            e.ext_onehot[p[5:0]] = 1'b1;
        end
        return e;
    endfunction : exp_route

    // Single comparison point, four-state exact
    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Verdict and end of run
    task automatic close_out();
        if (fails == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // Bus master tasks
    // ************************************************************
    // One bus cycle, launched right after a rising edge
    task automatic bus(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask : bus

    // Write, then idle so route has settled on return
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
        #1;
    endtask : wr

    // Read; data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1;
        v = reg_rdata;
    endtask : rd

    // Read both registers back and compare routing with the model
    task automatic check_all();
        rd(arcs_pkg::REF_SEL_OFS, rd_v);
        chk("ref_rd", {40'h0, rd_v}, {40'h0, ref_m});
        rd(arcs_pkg::PCH_SEL_OFS, rd_v);
        chk("pch_rd", {40'h0, rd_v}, {40'h0, pch_m});
        chk("route", {6'h0, route}, {6'h0, exp_route(ref_m, pch_m)});
    endtask : check_all

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Guard against a hung run
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        close_out();
    end

    initial begin
        clk_sys = 1'b0; rst_n = 1'b0; clk_en = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 16'h0000; reg_wdata = 8'h00; seed = 32'h540E3C17; fails = 0; n_tests = 0;
        ref_m = 8'h00; pch_m = 8'h00;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        check_all();
        // Every channel code with junk in the unused bits
        for (int i = 0; i < 64; i++) begin
            rnd = $random(seed);
            wr(arcs_pkg::PCH_SEL_OFS, {rnd[1:0], i[5:0]});
            pch_m = {2'h0, i[5:0]};
            check_all();
        end
        // Every reference code, both low-reference settings
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            wr(arcs_pkg::REF_SEL_OFS, {rnd[2:0], i[2], rnd[3:2], i[1:0]});
            ref_m = {3'h0, i[2], 2'h0, i[1:0]};
            check_all();
        end
        // Unmapped write is dropped, unmapped read is zero
        wr(16'h1D2A, 8'hFF);
        rd(16'h1D2A, rd_v);
        chk("unmapped", {40'h0, rd_v}, 48'h0);
        check_all();
        // Write then read with no gap; read data stand for one cycle only
        bus(1'b1, 1'b0, arcs_pkg::PCH_SEL_OFS, 8'hFF);
        bus(1'b0, 1'b1, arcs_pkg::PCH_SEL_OFS, 8'h00);
        bus(1'b0, 1'b0, arcs_pkg::PCH_SEL_OFS, 8'h00);
        #1;
        chk("wr_rd", {40'h0, reg_rdata}, {40'h0, 8'h3F});
        pch_m = 8'h3F;
        @(posedge clk_sys);
        #1;
        chk("rd_stand", {40'h0, reg_rdata}, 48'h0);
        // Write frozen while the clock enable is low
        clk_en <= 1'b0;
        wr(arcs_pkg::PCH_SEL_OFS, 8'h05);
        clk_en <= 1'b1;
        check_all();
        // Random traffic, mapped and unmapped
        for (int i = 0; i < 60; i++) begin
            rnd = $random(seed);
            reg_addr <= (rnd[1:0] == 2'h0) ? arcs_pkg::REF_SEL_OFS :
                        (rnd[1:0] == 2'h1) ? arcs_pkg::PCH_SEL_OFS : rnd[31:16];
            #1;
            wr(reg_addr, rnd[15:8]);
            if (reg_addr == arcs_pkg::REF_SEL_OFS) ref_m = rnd[15:8] & arcs_pkg::REF_SEL_MASK;
            if (reg_addr == arcs_pkg::PCH_SEL_OFS) pch_m = rnd[15:8] & arcs_pkg::PCH_SEL_MASK;
            check_all();
        end
        // Reset again in mid-run
        wr(arcs_pkg::REF_SEL_OFS, 8'h13);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        ref_m = 8'h00;
        pch_m = 8'h00;
        check_all();
        close_out();
    end
endmodule : tb_arcs_top
